// file: rtl/stx_map.svh
// register offsets, field positions and reset values of the transmitter
`ifndef STX_MAP_SVH
`define STX_MAP_SVH
`define STX_ADDR_DATA 2'h0
`define STX_ADDR_STATUS 2'h1
`define STX_ADDR_CTRL 2'h2
`define STX_ADDR_FORMAT 2'h3
// status register fields
`define STX_ST_COMPLETE 6
`define STX_ST_EMPTY 5
// control register fields
`define STX_CT_EMPTY_IE 5
`define STX_CT_COMPLETE_IE 6
`define STX_CT_ENABLE 3
`define STX_CT_NINTH 0
`define STX_CT_SIZE2 2
// format register fields
`define STX_FM_PAR_HI 5
`define STX_FM_PAR_LO 4
`define STX_FM_STOP2 3
`define STX_FM_SIZE_HI 2
`define STX_FM_SIZE_LO 1
`define STX_FMT_RESET 8'h06
`define STX_SIZE_NINE 3'h7
`define STX_DATA_BITS_BASE 4'h5
`define STX_BITS_NINE 4'h9
`endif

// file: rtl/stx_pkg.sv
// types of the serial transmitter
package stx_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP1, ST_STOP2
  } stx_state_e;
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } stx_bus_s;
  typedef struct packed {
    stx_state_e state;
    logic [8:0] buf_data;
    logic buf_full;
    logic [10:0] shift;
    logic [3:0] bit_cnt;
    logic [3:0] nbits;
    logic par_bit;
    logic par_en;
    logic two_stop;
    logic flag_complete;
    logic empty_ie;
    logic complete_ie;
    logic tx_en;
    logic ninth;
    logic [2:0] size;
    logic [1:0] par_mode;
    logic stop2;
    logic pin_own;
    logic txd;
    logic [7:0] rdata;
    logic irq_empty;
    logic irq_complete;
  } stx_state_s;
endpackage

// file: rtl/stx_top.sv
// serial transmitter with buffer-empty and transmit-complete flags
//
// Operation
// - ninth bit may mark address frames
// - empty flag set when buffer empty
// - empty flag clear while buffer pending
// - empty interrupt requested while flag set
// - data write loads buffer, clears flag
// - complete flag set after last frame
// - complete flag cleared by service or one
// - complete interrupt when flag set
// - parity bit before first stop bit
// - disable waits until all data sent
// - disabled transmitter releases output pin
// - buffer moves to idle or finished shifter
// - low start bit, data lsb first
// - unused high data bits ignored
// - enable takes over the output pin
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ns
`include "stx_map.svh"

module stx_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // baud tick, interrupt acknowledge and global enable
  input wire logic baud_tick_i,
  input wire logic global_ie_i,
  input wire logic complete_ack_i,
  // serial line and interrupt requests
  output logic txd_o,
  output logic txd_oe_o,
  output logic irq_empty_o,
  output logic irq_complete_o
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [3:0] data_bits(input logic [2:0] size);
    if (size == `STX_SIZE_NINE) begin
      data_bits = `STX_BITS_NINE;
    end else begin
      data_bits = `STX_DATA_BITS_BASE + {2'h0, size[1:0]};
    end
  endfunction

  function automatic logic [8:0] data_mask(input logic [3:0] n);
    data_mask = 9'h1ff >> (`STX_BITS_NINE - n);
  endfunction

  stx_pkg::stx_bus_s bus;
  stx_pkg::stx_state_s s_reg;
  stx_pkg::stx_state_s s_next;
  logic empty_flag;
  logic idle_done;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign empty_flag = !s_reg.buf_full;
  assign idle_done = s_reg.state == stx_pkg::ST_IDLE;

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [3:0] n;
    logic [8:0] d;
    logic load;
    logic last_stop;
    n = data_bits(s_reg.size);
    d = '0;
    load = 1'b0;
    last_stop = 1'b0;
    s_next = s_reg;
    s_next.rdata = 8'h00;
    // register writes
    if (bus.wr) begin
      unique case (bus.addr)
        `STX_ADDR_DATA: begin
          if (s_reg.tx_en && !s_reg.buf_full) begin
            s_next.buf_data = {s_reg.ninth, bus.wdata};
            s_next.buf_full = 1'b1;
          end
        end
        `STX_ADDR_STATUS: begin
          if (bus.wdata[`STX_ST_COMPLETE]) begin
            s_next.flag_complete = 1'b0;
          end
        end
        `STX_ADDR_CTRL: begin
          s_next.empty_ie = bus.wdata[`STX_CT_EMPTY_IE];
          s_next.complete_ie = bus.wdata[`STX_CT_COMPLETE_IE];
          s_next.tx_en = bus.wdata[`STX_CT_ENABLE];
          s_next.ninth = bus.wdata[`STX_CT_NINTH];
          s_next.size[2] = bus.wdata[`STX_CT_SIZE2];
        end
        `STX_ADDR_FORMAT: begin
          s_next.par_mode = bus.wdata[`STX_FM_PAR_HI:`STX_FM_PAR_LO];
          s_next.stop2 = bus.wdata[`STX_FM_STOP2];
          s_next.size[1:0] = bus.wdata[`STX_FM_SIZE_HI:`STX_FM_SIZE_LO];
        end
      endcase
    end
    if (complete_ack_i) begin
      s_next.flag_complete = 1'b0;
    end
    // register reads, data one cycle later
    if (bus.rd) begin
      unique case (bus.addr)
        `STX_ADDR_DATA: s_next.rdata = 8'h00;
        `STX_ADDR_STATUS: begin
          s_next.rdata[`STX_ST_COMPLETE] = s_reg.flag_complete;
          s_next.rdata[`STX_ST_EMPTY] = empty_flag;
        end
        `STX_ADDR_CTRL: begin
          s_next.rdata[`STX_CT_EMPTY_IE] = s_reg.empty_ie;
          s_next.rdata[`STX_CT_COMPLETE_IE] = s_reg.complete_ie;
          s_next.rdata[`STX_CT_ENABLE] = s_reg.tx_en;
          s_next.rdata[`STX_CT_NINTH] = s_reg.ninth;
          s_next.rdata[`STX_CT_SIZE2] = s_reg.size[2];
        end
        `STX_ADDR_FORMAT: begin
          s_next.rdata[`STX_FM_PAR_HI:`STX_FM_PAR_LO] = s_reg.par_mode;
          s_next.rdata[`STX_FM_STOP2] = s_reg.stop2;
          s_next.rdata[`STX_FM_SIZE_HI:`STX_FM_SIZE_LO] = s_reg.size[1:0];
        end
      endcase
    end
    // shifter, advances only on baud ticks
    if (baud_tick_i) begin
      unique case (s_reg.state)
        stx_pkg::ST_IDLE: load = s_reg.buf_full;
        stx_pkg::ST_START: begin
          s_next.state = stx_pkg::ST_DATA;
          s_next.txd = s_reg.shift[0];
          s_next.shift = s_reg.shift >> 1;
          s_next.bit_cnt = 4'h1;
        end
        stx_pkg::ST_DATA: begin
          if (s_reg.bit_cnt == s_reg.nbits) begin
            if (s_reg.par_en) begin
              s_next.state = stx_pkg::ST_PARITY;
              s_next.txd = s_reg.par_bit;
            end else begin
              s_next.state = stx_pkg::ST_STOP1;
              s_next.txd = 1'b1;
            end
          end else begin
            s_next.txd = s_reg.shift[0];
            s_next.shift = s_reg.shift >> 1;
            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
          end
        end
        stx_pkg::ST_PARITY: begin
          s_next.state = stx_pkg::ST_STOP1;
          s_next.txd = 1'b1;
        end
        stx_pkg::ST_STOP1: begin
          if (s_reg.two_stop) begin
            s_next.state = stx_pkg::ST_STOP2;
          end else begin
            last_stop = 1'b1;
          end
        end
        stx_pkg::ST_STOP2: last_stop = 1'b1;
      endcase
      if (last_stop) begin
        s_next.state = stx_pkg::ST_IDLE;
        load = s_reg.buf_full;
        if (!s_reg.buf_full) begin
          s_next.flag_complete = 1'b1;
        end
      end
    end
    if (load) begin
      d = s_reg.buf_data & data_mask(n);
      s_next.shift = {2'h0, d};
      s_next.nbits = n;
      s_next.par_bit = (^d) ^ s_reg.par_mode[0];
      s_next.par_en = s_reg.par_mode[1];
      s_next.two_stop = s_reg.stop2;
      s_next.state = stx_pkg::ST_START;
      s_next.txd = 1'b0;
      s_next.buf_full = 1'b0;
    end
    if (s_reg.state == stx_pkg::ST_IDLE && !load) begin
      s_next.txd = 1'b1;
    end
    // pin ownership: taken at enable, dropped only when drained
    if (s_reg.tx_en) begin
      s_next.pin_own = 1'b1;
    end else if (idle_done && !s_reg.buf_full) begin
      s_next.pin_own = 1'b0;
    end
    s_next.irq_empty = global_ie_i && s_next.empty_ie &&
                       !s_next.buf_full;
    s_next.irq_complete = global_ie_i && s_next.complete_ie &&
                          s_next.flag_complete;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_reg <= '0;
      s_reg.state <= stx_pkg::ST_IDLE;
      s_reg.txd <= 1'b1;
      s_reg.size <= 3'(`STX_FMT_RESET >> `STX_FM_SIZE_LO);
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_o = s_reg.rdata;
  assign txd_o = s_reg.txd;
  assign txd_oe_o = s_reg.pin_own;
  assign irq_empty_o = s_reg.irq_empty;
  assign irq_complete_o = s_reg.irq_complete;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  a_write_fills_buf: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_i && addr_i == `STX_ADDR_DATA && s_reg.tx_en && !s_reg.buf_full
    |=> s_reg.buf_full)
    else $error("data write did not fill the buffer");

  // a refused write leaves the buffer empty
  a_write_refused: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_i && addr_i == `STX_ADDR_DATA && !s_reg.tx_en && !s_reg.buf_full
    |=> !s_reg.buf_full)
    else $error("refused write filled the buffer");

  // request is registered with the flag, enable seen one cycle earlier
  a_empty_irq_level: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    $past(global_ie_i) && s_reg.empty_ie && empty_flag |-> irq_empty_o)
    else $error("empty interrupt missing");

  a_complete_irq: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    $past(global_ie_i) && s_reg.complete_ie && s_reg.flag_complete
    |-> irq_complete_o)
    else $error("complete interrupt missing");

  a_start_bit_low: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    s_reg.state == stx_pkg::ST_START |-> !txd_o)
    else $error("start bit not low");

  a_load_from_idle: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    baud_tick_i && s_reg.state == stx_pkg::ST_IDLE && s_reg.buf_full
    |=> s_reg.state == stx_pkg::ST_START && !s_reg.buf_full)
    else $error("idle shifter did not take the buffer");

  a_idle_line_high: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    $past(s_reg.state) == stx_pkg::ST_IDLE &&
    s_reg.state == stx_pkg::ST_IDLE |-> txd_o)
    else $error("idle line not high");

  a_complete_sets: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    baud_tick_i && s_reg.state == stx_pkg::ST_STOP2 && !s_reg.buf_full
    |=> s_reg.flag_complete)
    else $error("complete flag not set after frame");

  a_complete_one_stop: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    baud_tick_i && s_reg.state == stx_pkg::ST_STOP1 && !s_reg.two_stop &&
    !s_reg.buf_full |=> s_reg.flag_complete)
    else $error("complete flag not set after single stop");

  a_w1c_complete: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_i && addr_i == `STX_ADDR_STATUS && wdata_i[`STX_ST_COMPLETE] &&
    !(baud_tick_i && s_reg.state inside {stx_pkg::ST_STOP1,
    stx_pkg::ST_STOP2}) |=> !s_reg.flag_complete)
    else $error("complete flag not cleared");

  a_pin_held_busy: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    txd_oe_o && (s_reg.buf_full || s_reg.state != stx_pkg::ST_IDLE)
    |=> txd_oe_o)
    else $error("pin released with data pending");

  a_pin_released: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    !s_reg.tx_en && idle_done && !s_reg.buf_full |=> !txd_oe_o)
    else $error("drained transmitter kept the pin");

  a_enable_owns: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    s_reg.tx_en |=> txd_oe_o)
    else $error("enable did not take the pin");

  a_parity_slot: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    s_reg.state == stx_pkg::ST_PARITY |-> txd_o == s_reg.par_bit)
    else $error("wrong parity bit");

  c_frame_sent: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(s_reg.flag_complete));
  c_parity_frame: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    s_reg.state == stx_pkg::ST_PARITY);
  c_back_to_back: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    $past(s_reg.state) == stx_pkg::ST_STOP1 &&
    s_reg.state == stx_pkg::ST_START);
  c_pin_release: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    $fell(txd_oe_o));
  c_two_stop: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    s_reg.state == stx_pkg::ST_STOP2);

endmodule // stx_top

// file: tb/stx_rx_model.sv
// remote serial receiver model sampling the line at each baud tick
`timescale 1ns/1ns
module stx_rx_model (
  // clock and line
  input wire logic clk_i,
  input wire logic tick_i,
  input wire logic txd_i,
  input wire logic txd_oe_i,
  // bits expected after the start bit
  input wire logic [3:0] nb_i,
  // captured frame
  output logic [11:0] frame_o,
  output logic done_o
);
  logic line;
  logic busy = 1'b0;
  logic [3:0] idx = 4'h0;
  // pull-up holds a released line high
  assign line = txd_oe_i ? txd_i : 1'b1;
  initial done_o = 1'b0;
  initial frame_o = 12'h000;
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (tick_i && !busy && !line) begin
      busy <= 1'b1;
      idx <= 4'h0;
      frame_o <= 12'h000;
    end else if (tick_i && busy) begin
      frame_o[idx] <= line;
      idx <= idx + 4'h1;
      if (idx + 4'h1 == nb_i) begin
        busy <= 1'b0;
        done_o <= 1'b1;
      end
    end
  end
endmodule // stx_rx_model

// file: tb/stx_top_tb_top.sv
// self-checking bench of the serial transmitter
`timescale 1ns/1ns
module stx_top_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic tick = 1'b0;
  logic gie = 1'b0;
  logic ack = 1'b0;
  logic [1:0] tcnt = 2'h0;
  logic [3:0] nb = 4'h9;
  logic [7:0] rdata;
  logic [7:0] v;
  logic [11:0] frame;
  logic txd, txd_oe, irq_e, irq_c, done;
  int error_cnt = 0;
  int checked = 0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    tcnt <= tcnt + 2'h1;
    tick <= (tcnt == 2'h3);
  end
  stx_top dut_u (.clk_i(clk), .rst_b_i(rst_b), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .baud_tick_i(tick), .global_ie_i(gie), .complete_ack_i(ack),
    .txd_o(txd), .txd_oe_o(txd_oe), .irq_empty_o(irq_e),
    .irq_complete_o(irq_c));
  stx_rx_model rx_u (.clk_i(clk), .tick_i(tick), .txd_i(txd),
    .txd_oe_i(txd_oe), .nb_i(nb), .frame_o(frame), .done_o(done));
  //////////////////////////////////////////////
  task chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rst(input logic [7:0] exp);
    @(posedge clk);
    addr <= 2'h1;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    chk({4'h0, v}, {4'h0, exp});
  endtask
  task wait_empty;
    do begin
      @(posedge clk);
      addr <= 2'h1;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
    end while (v[5] !== 1'b1);
  endtask
  task rx(input logic [3:0] n, input logic [11:0] exp);
    int i;
    nb = n;
    i = 0;
    do begin
      @(posedge clk);
      #1 i++;
    end while (done !== 1'b1 && i < 400);
    chk(frame, exp);
  endtask
  //////////////////////////////////////////////
  task t_basic;
    chk({8'h0, txd, txd_oe, irq_e, irq_c}, 12'h008);
    rst(8'h20);
    wreg(2'h2, 8'h08);
    @(posedge clk);
    #1 chk({11'h0, txd_oe}, 12'h001);
    wreg(2'h0, 8'ha5);
    wait_empty;
    wreg(2'h0, 8'h3c);
    rst(8'h00);
    rx(4'h9, 12'h1a5);
    rx(4'h9, 12'h13c);
    repeat (8) @(posedge clk);
    rst(8'h60);
    wreg(2'h1, 8'h40);
    rst(8'h20);
    $display("t_basic done");
  endtask
  task t_format;
    int m;
    for (m = 0; m < 2; m++) begin
      wreg(2'h3, m ? 8'h36 : 8'h26);
      wreg(2'h0, 8'h07);
      rx(4'ha, m ? 12'h207 : 12'h307);
      repeat (8) @(posedge clk);
    end
    wreg(2'h3, 8'h06);
    wreg(2'h2, 8'h0d);
    wreg(2'h0, 8'h00);
    rx(4'ha, 12'h300);
    repeat (8) @(posedge clk);
    wreg(2'h2, 8'h08);
    wreg(2'h3, 8'h08);
    wreg(2'h0, 8'hc0);
    rx(4'h6, 12'h020);
    repeat (8) @(posedge clk);
    wreg(2'h3, 8'h04);
    wreg(2'h0, 8'h40);
    rx(4'h8, 12'h0c0);
    repeat (8) @(posedge clk);
    wreg(2'h3, 8'h06);
    $display("t_format done");
  endtask
  task t_irq;
    wreg(2'h1, 8'h40);
    gie <= 1'b1;
    wreg(2'h2, 8'h68);
    repeat (3) @(posedge clk);
    #1 chk({10'h0, irq_e, irq_c}, 12'h002);
    wreg(2'h0, 8'h81);
    wait_empty;
    wreg(2'h0, 8'h42);
    repeat (2) @(posedge clk);
    #1 chk({10'h0, irq_e, irq_c}, 12'h000);
    rx(4'h9, 12'h181);
    rx(4'h9, 12'h142);
    repeat (8) @(posedge clk);
    #1 chk({10'h0, irq_e, irq_c}, 12'h003);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({10'h0, irq_e, irq_c}, 12'h002);
    wreg(2'h2, 8'h08);
    repeat (2) @(posedge clk);
    #1 chk({10'h0, irq_e, irq_c}, 12'h000);
    gie <= 1'b0;
    $display("t_irq done");
  endtask
  task t_disable;
    wreg(2'h0, 8'h11);
    wait_empty;
    wreg(2'h0, 8'h22);
    wreg(2'h2, 8'h00);
    rx(4'h9, 12'h111);
    chk({11'h0, txd_oe}, 12'h001);
    rx(4'h9, 12'h122);
    repeat (8) @(posedge clk);
    #1 chk({11'h0, txd_oe}, 12'h000);
    $display("t_disable done");
  endtask
  task t_reset;
    wreg(2'h2, 8'h08);
    wreg(2'h0, 8'h55);
    repeat (12) @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1 chk({8'h0, txd, txd_oe, irq_e, irq_c}, 12'h008);
    wreg(2'h0, 8'h55);
    rst(8'h20);
    $display("t_reset done");
  endtask
  //////////////////////////////////////////////
  task test_done;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1 t_basic;
    t_format;
    t_irq;
    t_disable;
    t_reset;
    test_done;
  end
  // watchdog well beyond the expected run of about 600 cycles
  initial begin
    repeat (6000) @(posedge clk);
    error_cnt++;
    test_done;
  end
endmodule // stx_top_tb_top
